// ===== logic/blit_vector_pkg.sv
// Constants for the drawing-engine parameter and control register bank.
// Assumes a 32-bit word-wide memory access port on the core clock.
// Operation
// - A transfer mode write starts a block transfer on current geometry; here the start is dropped while the engine is busy.
// - Status register holds configuration; flags sit in its low byte.
// - Legacy base register gives emulated video memory offset.
// - Display latch register is readable and writable by memory access.
// - Destination register bits 31:16 hold signed destination or start row.
// - Destination bits 15:0 hold signed destination or start column.
// - Transfer width and height count pixels; zero in either renders nothing.
// - Vector length uses a 14-bit field; upper bits reserved.
// - Transfer source register: signed column in 31:16, signed row in 15:0.
// - Vector mode: signed axial error in 31:16, signed slant error in 15:0.
// - Offsets 8140h, 8144h, 8210h, 8214h serve legacy video emulation; only 8210h and 8214h are decoded here.
// - A line draw start write starts a vector on current geometry; here the start is dropped while the engine is busy.
package blit_vector_pkg;
  localparam logic [15:0] OFS_DEST   = 16'h8100;
  localparam logic [15:0] OFS_SIZE   = 16'h8104;
  localparam logic [15:0] OFS_SRC    = 16'h8108;
  localparam logic [15:0] OFS_LINE   = 16'h8204;
  localparam logic [15:0] OFS_XFER   = 16'h8208;
  localparam logic [15:0] OFS_STATE  = 16'h820C;
  localparam logic [15:0] OFS_VBASE  = 16'h8210;
  localparam logic [15:0] OFS_VLATCH = 16'h8214;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam int          HI_LSB     = 16;
  localparam int          LEN_W      = 14;
  localparam int          BUSY_BIT   = 0;
  localparam int          FLAG_BYTE  = 8;
  localparam logic [15:0] ZERO_HALF  = 16'h0000;
  localparam logic [15:0] ONE_HALF   = 16'h0001;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_LINE = 2'b10
  } eng_state_type;
endpackage

// ===== logic/op_sequencer.sv
// Operation sequencer: counts out a started transfer or vector.
// Assumes one-cycle start pulses from the register bank, same clock.
`timescale 1ns/1ns
module op_sequencer
  import blit_vector_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_start_xfer,
  input  wire logic        i_start_line,
  input  wire logic [15:0] i_width,
  input  wire logic [15:0] i_height,
  input  wire logic [13:0] i_length,
  output logic             o_busy,
  output logic             o_pixel
);
  eng_state_type state_q, state_d;
  logic [15:0] col_q, col_d, row_q, row_d;
  logic pix_q, pix_d;

  always_comb begin
    state_d = state_q;
    col_d   = col_q;
    row_d   = row_q;
    pix_d   = 1'b0;
    case (state_q)
      ST_IDLE: begin
        col_d = ZERO_HALF;
        row_d = ZERO_HALF;
        // A zero width or height renders nothing at all.
        if (i_start_xfer && i_width != ZERO_HALF &&
            i_height != ZERO_HALF) begin
          state_d = ST_XFER;
        end else if (i_start_line &&
                     i_length != ZERO_HALF[13:0]) begin
          state_d = ST_LINE;
        end
      end
      ST_XFER: begin
        pix_d = 1'b1;
        if (col_q + ONE_HALF == i_width) begin
          col_d = ZERO_HALF;
          if (row_q + ONE_HALF == i_height) begin
            state_d = ST_IDLE;
          end else begin
            row_d = row_q + ONE_HALF;
          end
        end else begin
          col_d = col_q + ONE_HALF;
        end
      end
      ST_LINE: begin
        pix_d = 1'b1;
        if (col_q[13:0] + ONE_HALF[13:0] == i_length) begin
          state_d = ST_IDLE;
        end else begin
          col_d = col_q + ONE_HALF;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= ST_IDLE;
      col_q   <= ZERO_HALF;
      row_q   <= ZERO_HALF;
      pix_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      col_q   <= col_d;
      row_q   <= row_d;
      pix_q   <= pix_d;
    end
  end

  assign o_busy  = (state_q != ST_IDLE);
  assign o_pixel = pix_q;
endmodule

// ===== logic/blit_vector_param_regs.sv
// Parameter and control register bank of the 2D drawing engine.
// Assumes a simple synchronous word access port from the processor core.
`timescale 1ns/1ns
module blit_vector_param_regs
  import blit_vector_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [15:0] i_addr,
  input  wire logic [31:0] i_wdata,
  output logic [31:0]      o_rdata,
  output logic             o_busy,
  output logic             o_pixel,
  output logic             o_start_xfer,
  output logic             o_start_line,
  output logic [15:0]      o_dest_row,
  output logic [15:0]      o_dest_col,
  output logic [15:0]      o_width,
  output logic [15:0]      o_height,
  output logic [13:0]      o_line_len,
  output logic [15:0]      o_line_init_err,
  output logic [15:0]      o_source_column,
  output logic [15:0]      o_source_row,
  output logic [31:0]      o_transfer_start_mode,
  output logic [31:0]      o_line_draw_start,
  output logic [31:0]      o_legacy_video_mem_offset,
  output logic [31:0]      o_legacy_display_latch,
  input  wire logic        i_latch_load,
  input  wire logic [31:0] i_latch_data
);
  logic [31:0] dest_q, dest_d, size_q, size_d, src_q, src_d;
  logic [31:0] xmode_q, xmode_d, lmode_q, lmode_d, cfg_q, cfg_d;
  logic [31:0] vbase_q, vbase_d, vlatch_q, vlatch_d, rdata_q, rdata_d;
  logic        sx_q, sx_d, sl_q, sl_d;
  logic        busy;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a[15:2] == o[15:2]);
  endfunction

  // Writes only replace the addressed word, so geometry persists.
  always_comb begin
    dest_d   = dest_q;
    size_d   = size_q;
    src_d    = src_q;
    xmode_d  = xmode_q;
    lmode_d  = lmode_q;
    cfg_d    = cfg_q;
    vbase_d  = vbase_q;
    vlatch_d = vlatch_q;
    sx_d     = 1'b0;
    sl_d     = 1'b0;
    // Starts while busy are dropped; software loads all geometry first.
    if (i_latch_load) begin
      vlatch_d = i_latch_data;
    end
    if (i_wr) begin
      if (hit(i_addr, OFS_DEST))   dest_d = i_wdata;
      if (hit(i_addr, OFS_SIZE))   size_d = i_wdata;
      if (hit(i_addr, OFS_SRC))    src_d  = i_wdata;
      if (hit(i_addr, OFS_XFER)) begin
        xmode_d = i_wdata;
        sx_d    = !busy;
      end
      if (hit(i_addr, OFS_LINE)) begin
        lmode_d = i_wdata;
        sl_d    = !busy;
      end
      if (hit(i_addr, OFS_STATE)) begin
        cfg_d = {i_wdata[31:FLAG_BYTE], RESET_WORD[FLAG_BYTE-1:0]};
      end
      if (hit(i_addr, OFS_VBASE))  vbase_d  = i_wdata;
      if (hit(i_addr, OFS_VLATCH)) vlatch_d = i_wdata;
    end
  end

  always_comb begin
    rdata_d = rdata_q;
    if (i_rd) begin
      rdata_d = RESET_WORD;
      if (hit(i_addr, OFS_DEST))   rdata_d = dest_q;
      if (hit(i_addr, OFS_SIZE))   rdata_d = size_q;
      if (hit(i_addr, OFS_SRC))    rdata_d = src_q;
      if (hit(i_addr, OFS_XFER))   rdata_d = xmode_q;
      if (hit(i_addr, OFS_LINE))   rdata_d = lmode_q;
      // Live engine state in the low byte.
      if (hit(i_addr, OFS_STATE)) begin
        rdata_d = cfg_q;
        rdata_d[BUSY_BIT] = busy;
      end
      if (hit(i_addr, OFS_VBASE))  rdata_d = vbase_q;
      if (hit(i_addr, OFS_VLATCH)) rdata_d = vlatch_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dest_q   <= RESET_WORD;
      size_q   <= RESET_WORD;
      src_q    <= RESET_WORD;
      xmode_q  <= RESET_WORD;
      lmode_q  <= RESET_WORD;
      cfg_q    <= RESET_WORD;
      vbase_q  <= RESET_WORD;
      vlatch_q <= RESET_WORD;
      rdata_q  <= RESET_WORD;
      sx_q     <= 1'b0;
      sl_q     <= 1'b0;
    end else begin
      dest_q   <= dest_d;
      size_q   <= size_d;
      src_q    <= src_d;
      xmode_q  <= xmode_d;
      lmode_q  <= lmode_d;
      cfg_q    <= cfg_d;
      vbase_q  <= vbase_d;
      vlatch_q <= vlatch_d;
      rdata_q  <= rdata_d;
      sx_q     <= sx_d;
      sl_q     <= sl_d;
    end
  end

  op_sequencer u_seq (
    .i_clk        (i_clk),
    .i_arst_n     (i_arst_n),
    .i_start_xfer (sx_q),
    .i_start_line (sl_q),
    .i_width      (size_q[31:HI_LSB]),
    .i_height     (size_q[HI_LSB-1:0]),
    .i_length     (size_q[HI_LSB+LEN_W-1:HI_LSB]),
    .o_busy       (busy),
    .o_pixel      (o_pixel)
  );

  assign o_rdata                   = rdata_q;
  assign o_busy                    = busy;
  assign o_start_xfer              = sx_q;
  assign o_start_line              = sl_q;
  assign o_dest_row                = dest_q[31:HI_LSB];
  assign o_dest_col                = dest_q[HI_LSB-1:0];
  assign o_width                   = size_q[31:HI_LSB];
  assign o_height                  = size_q[HI_LSB-1:0];
  assign o_line_len                = size_q[HI_LSB+LEN_W-1:HI_LSB];
  assign o_line_init_err           = size_q[HI_LSB-1:0];
  assign o_source_column           = src_q[31:HI_LSB];
  assign o_source_row              = src_q[HI_LSB-1:0];
  assign o_transfer_start_mode     = xmode_q;
  assign o_line_draw_start         = lmode_q;
  assign o_legacy_video_mem_offset = vbase_q;
  assign o_legacy_display_latch    = vlatch_q;
endmodule

// ===== bench/blit_regs_sva.sv
// Checker of the drawing-engine register bank, bound to its top.
// Assumes word offsets from the package and one-cycle start pulses.
`timescale 1ns/1ns
module blit_regs_sva
  import blit_vector_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic        i_wr,
  input wire logic [15:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        o_busy,
  input wire logic        o_pixel,
  input wire logic        o_start_xfer,
  input wire logic        o_start_line,
  input wire logic [15:0] o_dest_row,
  input wire logic [15:0] o_dest_col,
  input wire logic [15:0] o_width,
  input wire logic [15:0] o_height,
  input wire logic [13:0] o_line_len,
  input wire logic [15:0] o_source_column,
  input wire logic [15:0] o_source_row
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire logic [13:0] wa = i_addr[15:2];
  wire logic idle = !o_busy && !o_start_xfer && !o_start_line;
  xfer_start_a: assert property (
    i_wr && wa == OFS_XFER[15:2] && idle |=> o_start_xfer)
    else $error("transfer start pulse missing");
  line_start_a: assert property (
    i_wr && wa == OFS_LINE[15:2] && idle |=> o_start_line)
    else $error("line start pulse missing");
  xfer_run_a: assert property (
    o_start_xfer && o_width != ZERO_HALF && o_height != ZERO_HALF
    |=> o_busy) else $error("engine not busy after start");
  zero_size_a: assert property (
    o_start_xfer && (o_width == ZERO_HALF || o_height == ZERO_HALF)
    |=> (!o_busy && !o_pixel)[*3]) else $error("zero size drew pixels");
  dest_fields_a: assert property (
    i_wr && wa == OFS_DEST[15:2] |=> {o_dest_row, o_dest_col} ==
    $past(i_wdata)) else $error("destination fields wrong");
  src_fields_a: assert property (
    i_wr && wa == OFS_SRC[15:2] |=> {o_source_column, o_source_row} ==
    $past(i_wdata)) else $error("source fields wrong");
  size_fields_a: assert property (
    i_wr && wa == OFS_SIZE[15:2] |=> {o_width, o_height} == $past(i_wdata)
    && o_line_len == o_width[13:0]) else $error("size fields wrong");
  params_hold_a: assert property (
    !i_wr |=> $stable({o_dest_row, o_dest_col, o_width, o_height,
    o_source_column, o_source_row})) else $error("parameter changed");
endmodule
bind blit_vector_param_regs blit_regs_sva u_sva (.*);

// ===== bench/testbench.sv
// Self-checking bench for the drawing-engine register bank.
// Assumes the bank alone, driven on falling clock edges.
`timescale 1ns/1ns
module testbench;
  import blit_vector_pkg::*;
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, ld = 0;
  logic [15:0] a = 0, dr, dc, sc, sr, ie;
  logic [31:0] wd = 0, ldd = 0, rdat, xm, lm, vb, vl;
  logic        busy, pix;
  int          miscompares = 0, comparisons = 0;
  logic [15:0] ofs [6] = '{OFS_DEST, OFS_SRC, OFS_VBASE, OFS_VLATCH,
                           OFS_XFER, OFS_LINE};
  blit_vector_param_regs u_dut (.i_clk(clk), .i_arst_n(rst_n), .i_wr(wr),
    .i_rd(rd), .i_addr(a), .i_wdata(wd), .o_rdata(rdat), .o_busy(busy),
    .o_pixel(pix), .o_start_xfer(), .o_start_line(), .o_dest_row(dr),
    .o_dest_col(dc), .o_width(), .o_height(), .o_line_len(),
    .o_line_init_err(ie), .o_source_column(sc), .o_source_row(sr),
    .o_transfer_start_mode(xm), .o_line_draw_start(lm),
    .o_legacy_video_mem_offset(vb), .o_legacy_display_latch(vl),
    .i_latch_load(ld), .i_latch_data(ldd));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrw(input logic [15:0] ad, input logic [31:0] d);
    @(negedge clk);
    wr = 1;
    a = ad;
    wd = d;
    @(negedge clk);
    wr = 0;
  endtask
  task automatic rdw(input logic [15:0] ad, input logic [31:0] e);
    @(negedge clk);
    rd = 1;
    a = ad;
    @(negedge clk);
    rd = 0;
    @(negedge clk);
    chk(rdat, e);
  endtask
  task automatic pixels(input int e);
    logic [31:0] n;
    n = 32'h0000_0000;
    repeat (40) begin
      @(negedge clk);
      n += pix;
    end
    chk(n, e);
  endtask
  task automatic t_regs;
    foreach (ofs[i]) rdw(ofs[i], 32'h0000_0000);
    foreach (ofs[i]) wrw(ofs[i], 32'h8001_7FF0 + i);
    foreach (ofs[i]) rdw(ofs[i], 32'h8001_7FF0 + i);
    pixels(0);
    chk({dr, dc}, 32'h8001_7FF0);
    chk({sc, sr}, 32'h8001_7FF1);
    chk(vb, 32'h8001_7FF2);
    chk(vl, 32'h8001_7FF3);
    chk(xm, 32'h8001_7FF4);
    chk(lm, 32'h8001_7FF5);
    rdw(16'h8118, 32'h0000_0000);
    $display("test regs done");
  endtask
  task automatic t_ops;
    wrw(OFS_SIZE, 32'h0002_0003);
    chk({ZERO_HALF, ie}, 32'h0000_0003);
    wrw(OFS_XFER, 32'h0000_0000);
    pixels(6);
    wrw(OFS_SIZE, 32'hC005_0000);
    wrw(OFS_LINE, 32'h0000_0000);
    pixels(5);
    rdw(OFS_DEST, 32'h8001_7FF0);
    // A 2 by 2 transfer: the status read lands while it runs.
    wrw(OFS_SIZE, 32'h0002_0002);
    wrw(OFS_XFER, 32'h0000_0000);
    rdw(OFS_STATE, 32'h0000_0001);
    pixels(2);
    wrw(OFS_STATE, 32'h1234_56FF);
    rdw(OFS_STATE, 32'h1234_5600);
    $display("test operations done");
  endtask
  task automatic t_latch;
    @(negedge clk);
    ld = 1;
    ldd = 32'h1234_5678;
    @(negedge clk);
    ld = 0;
    rdw(OFS_VLATCH, 32'h1234_5678);
    $display("test latch done");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #40000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1;
    t_regs();
    t_ops();
    t_latch();
    report_and_stop();
  end
endmodule
